// ===== include/ast_pkg.sv
// Constants and types for the asynchronous serial transmitter/receiver.
// Assumes a single core clock; the 16x sampling tick comes from ast_baud.
package ast_pkg;

	// ------------------------------------------------------------
	// Oversampling and bit timing
	// ------------------------------------------------------------
	localparam int unsigned OVS_RATE    = 16;
	localparam logic [3:0]  OVS_LAST    = 4'(OVS_RATE - 1);
	localparam logic [3:0]  SAMPLE_PH   = 4'h7;
	localparam logic [3:0]  CLK_RISE_PH = 4'h8;
	localparam logic [3:0]  PH_ZERO     = 4'h0;
	localparam logic [3:0]  PH_STEP     = 4'h1;

	// ------------------------------------------------------------
	// Character format
	// ------------------------------------------------------------
	localparam logic [2:0] LAST_BIT_8 = 3'h7;
	localparam logic [2:0] LAST_BIT_7 = 3'h6;
	localparam logic [2:0] IDX_ZERO   = 3'h0;
	localparam logic [2:0] IDX_STEP   = 3'h1;
	localparam logic       MARK       = 1'b1;
	localparam logic       SPACE      = 1'b0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] DIV_RST  = 8'h00;
	localparam logic [7:0] DIV_STEP = 8'h01;
	localparam logic       TX_BUFFER_EMPTY_FLAG_RST = 1'b1;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} ast_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ast_rx_e;

endpackage

// ===== rtl/ast_baud.sv
// Sixteen-times bit-rate tick source.
// Assumes the external clock pin is asynchronous to the core clock.
`timescale 1ns/1ps
module ast_baud
	import ast_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       arst_n_i,
	// Configuration
	input  wire logic       ext_sel_i,
	input  wire logic [7:0] bit_rate_i,
	// External clock pin
	input  wire logic       ser_clk_pin_i,
	// Tick
	output logic            tick_o
);

	logic [7:0] div_reg;
	logic       pin_meta_reg;
	logic       pin_sync_reg;
	logic       pin_last_reg;

	wire div_zero = (div_reg == DIV_RST);
	wire pin_rise = pin_sync_reg & ~pin_last_reg;

	// ------------------------------------------------------------
	// Programmable divider
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_reg <= DIV_RST;
		end else begin
			div_reg <= div_zero ? bit_rate_i : div_reg - DIV_STEP;
		end
	end

	// ------------------------------------------------------------
	// External clock synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_last_reg <= 1'b0;
		end else begin
			pin_meta_reg <= ser_clk_pin_i;
			pin_sync_reg <= pin_meta_reg;
			pin_last_reg <= pin_sync_reg;
		end
	end

	assign tick_o = ext_sel_i ? pin_rise : div_zero;

endmodule

// ===== rtl/ast_txrx.sv
// Asynchronous serial transmitter/receiver with double buffering.
// Assumes software drives the control ports and clears flags by pulses.
`timescale 1ns/1ps

module ast_txrx
	import ast_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       arst_n_i,
	// Format
	input  wire logic       chr_7bit_i,
	input  wire logic       parity_en_i,
	input  wire logic       odd_parity_sel_i,
	input  wire logic       mp_mode_i,
	input  wire logic       two_stop_i,
	input  wire logic [7:0] bit_rate_i,
	// Control
	input  wire logic       clk_src_sel_hi_i,
	input  wire logic       clk_src_sel_lo_i,
	input  wire logic       tx_on_i,
	input  wire logic       rx_on_i,
	input  wire logic       tx_irq_en_i,
	input  wire logic       rx_irq_en_i,
	input  wire logic       done_irq_en_i,
	input  wire logic       break_pin_level_i,
	input  wire logic       break_pin_drive_i,
	// Transmit data and flag clears
	input  wire logic [7:0] tx_hold_data_i,
	input  wire logic       tx_hold_we_i,
	input  wire logic       addr_flag_bit_i,
	input  wire logic       tx_empty_clr_i,
	// Receive flag clears
	input  wire logic       rx_full_clr_i,
	input  wire logic       parity_fault_clr_i,
	input  wire logic       framing_fault_clr_i,
	input  wire logic       overrun_clr_i,
	// Status
	output logic            tx_buffer_empty_flag_o,
	output logic            tx_done_flag_o,
	output logic            rx_full_flag_o,
	output logic            parity_fault_flag_o,
	output logic            framing_fault_flag_o,
	output logic            overrun_flag_o,
	output logic [7:0]      rx_hold_o,
	// Interrupt requests
	output logic            tx_empty_irq_o,
	output logic            tx_done_irq_o,
	output logic            rx_full_irq_o,
	output logic            rx_error_irq_o,
	// Pins
	input  wire logic       rx_line_i,
	output logic            tx_line_o,
	output logic            tx_line_oe_o,
	input  wire logic       ser_clk_pin_i,
	output logic            ser_clk_pin_o,
	output logic            ser_clk_pin_oe_o
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	ast_tx_e    tx_state_reg;
	ast_tx_e    tx_state_next;
	ast_rx_e    rx_state_reg;
	ast_rx_e    rx_state_next;
	logic       tick;
	logic [3:0] tx_phase_reg;
	logic [2:0] tx_idx_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] tx_shift_reg;
	logic       tx_mpb_reg;
	logic       tx_chain_reg;
	logic       tx_second_reg;
	logic       tx_line_reg;
	logic       tx_line_next;
	logic       ser_clk_reg;
	logic       tx_buffer_empty_flag_reg;
	logic       tx_done_flag_reg;
	logic       rx_meta_reg;
	logic       rx_line_reg;
	logic [3:0] rx_cnt_reg;
	logic [2:0] rx_idx_reg;
	logic [7:0] rx_shift_reg;
	logic       rx_par_reg;
	logic [7:0] rx_hold_reg;
	logic       rx_full_flag_reg;
	logic       per_reg;
	logic       fer_reg;
	logic       overrun_flag_reg;

	// ------------------------------------------------------------
	// Tick source
	// ------------------------------------------------------------
	ast_baud u_baud (
		.core_clk_i    (core_clk_i),
		.arst_n_i      (arst_n_i),
		.ext_sel_i     (clk_src_sel_hi_i),
		.bit_rate_i    (bit_rate_i),
		.ser_clk_pin_i (ser_clk_pin_i),
		.tick_o        (tick)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire       par_slot   = parity_en_i | mp_mode_i;
	wire [2:0] last_bit   = chr_7bit_i ? LAST_BIT_7 : LAST_BIT_8;
	wire       bit_end    = tick & (tx_phase_reg == OVS_LAST);
	wire       bit_mid    = tick & (tx_phase_reg == SAMPLE_PH);
	wire       tx_last    = (tx_idx_reg == last_bit);
	wire       stop_entry = bit_end & ((tx_state_reg == TX_PAR) |
	                        ((tx_state_reg == TX_DATA) & tx_last & ~par_slot));
	wire       tx_load    = tx_on_i & ~tx_buffer_empty_flag_reg &
	                        ((tx_state_reg == TX_IDLE) | stop_entry);
	wire       tx_finish  = stop_entry & tx_buffer_empty_flag_reg;
	wire       tx_stop_end = bit_end & (tx_state_reg == TX_STOP) &
	                        (~two_stop_i | tx_second_reg);
	wire [7:0] tx_data    = {tx_shift_reg[7] & ~chr_7bit_i, tx_shift_reg[6:0]};
	wire       tx_par_bit = mp_mode_i ? tx_mpb_reg : (^tx_data) ^ odd_parity_sel_i;

	wire       rx_err_any = per_reg | fer_reg | overrun_flag_reg;
	wire       rx_begin   = rx_on_i & ~rx_err_any & (rx_state_reg == RX_IDLE) &
	                        (rx_line_reg == SPACE);
	wire       rx_sample  = tick & (rx_cnt_reg == SAMPLE_PH) & (rx_state_reg != RX_IDLE);
	wire       rx_last    = (rx_idx_reg == last_bit);
	wire       rx_done    = rx_on_i & rx_sample & (rx_state_reg == RX_STOP);
	wire [7:0] rx_data    = {rx_shift_reg[7] & ~chr_7bit_i, rx_shift_reg[6:0]};
	wire       par_bad    = parity_en_i & ~mp_mode_i &
	                        (((^rx_data) ^ rx_par_reg) != odd_parity_sel_i);
	wire       stop_bad   = (rx_line_reg == SPACE);

	// ------------------------------------------------------------
	// Transmit state machine
	// ------------------------------------------------------------
	always_comb begin
		tx_state_next = tx_state_reg;
		case (tx_state_reg)
			TX_IDLE:  if (tx_load) tx_state_next = TX_WAIT;
			TX_WAIT:  if (bit_end) tx_state_next = TX_START;
			TX_START: if (bit_end) tx_state_next = TX_DATA;
			TX_DATA: begin
				if (bit_end && tx_last) begin
					tx_state_next = par_slot ? TX_PAR : TX_STOP;
				end
			end
			TX_PAR:   if (bit_end) tx_state_next = TX_STOP;
			TX_STOP: begin
				if (tx_stop_end) begin
					tx_state_next = tx_chain_reg ? TX_START : TX_IDLE;
				end
			end
			default:  tx_state_next = TX_IDLE;
		endcase
		if (!tx_on_i) begin
			tx_state_next = TX_IDLE;
		end
	end

	always_comb begin
		case (tx_state_reg)
			TX_START: tx_line_next = SPACE;
			TX_DATA:  tx_line_next = tx_shift_reg[tx_idx_reg];
			TX_PAR:   tx_line_next = tx_par_bit;
			default:  tx_line_next = MARK;
		endcase
		if (!tx_on_i) begin
			tx_line_next = break_pin_drive_i ? break_pin_level_i : MARK;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_state_reg <= TX_IDLE;
			tx_line_reg  <= MARK;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_line_reg  <= tx_line_next;
		end
	end

	// ------------------------------------------------------------
	// Transmit phase, clock output and bit index
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_phase_reg <= PH_ZERO;
			ser_clk_reg  <= 1'b0;
		end else begin
			tx_phase_reg <= tick ? tx_phase_reg + PH_STEP : tx_phase_reg;
			ser_clk_reg  <= (tx_phase_reg >= CLK_RISE_PH);
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_idx_reg    <= IDX_ZERO;
			tx_second_reg <= 1'b0;
		end else if (bit_end) begin
			tx_idx_reg    <= (tx_state_reg == TX_DATA) ? tx_idx_reg + IDX_STEP : IDX_ZERO;
			tx_second_reg <= (tx_state_reg == TX_STOP) & ~tx_second_reg;
		end
	end

	// ------------------------------------------------------------
	// Transmit buffers and flags
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_hold_reg <= DATA_RST;
		end else if (tx_hold_we_i) begin
			tx_hold_reg <= tx_hold_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_shift_reg <= DATA_RST;
			tx_mpb_reg   <= 1'b0;
			tx_chain_reg <= 1'b0;
		end else if (!tx_on_i) begin
			tx_shift_reg <= DATA_RST;
			tx_chain_reg <= 1'b0;
		end else begin
			if (tx_load) begin
				tx_shift_reg <= tx_hold_reg;
				tx_mpb_reg   <= addr_flag_bit_i;
			end
			if (stop_entry) begin
				tx_chain_reg <= tx_load;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_buffer_empty_flag_reg <= TX_BUFFER_EMPTY_FLAG_RST;
			tx_done_flag_reg <= TX_BUFFER_EMPTY_FLAG_RST;
		end else begin
			tx_buffer_empty_flag_reg <= ~tx_on_i | tx_load | (tx_buffer_empty_flag_reg & ~tx_empty_clr_i);
			tx_done_flag_reg <= tx_finish | (tx_done_flag_reg & ~tx_empty_clr_i);
		end
	end

	// ------------------------------------------------------------
	// Receive synchroniser and state machine
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_meta_reg <= MARK;
			rx_line_reg <= MARK;
		end else begin
			rx_meta_reg <= rx_line_i;
			rx_line_reg <= rx_meta_reg;
		end
	end

	always_comb begin
		rx_state_next = rx_state_reg;
		case (rx_state_reg)
			RX_IDLE:  if (rx_begin) rx_state_next = RX_START;
			RX_START: begin
				if (rx_sample) begin
					rx_state_next = (rx_line_reg == SPACE) ? RX_DATA : RX_IDLE;
				end
			end
			RX_DATA: begin
				if (rx_sample && rx_last) begin
					rx_state_next = par_slot ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR:   if (rx_sample) rx_state_next = RX_STOP;
			RX_STOP:  if (rx_sample) rx_state_next = RX_IDLE;
			default:  rx_state_next = RX_IDLE;
		endcase
		if (!rx_on_i) begin
			rx_state_next = RX_IDLE;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= PH_ZERO;
		end else begin
			rx_state_reg <= rx_state_next;
			if (rx_state_reg == RX_IDLE) begin
				rx_cnt_reg <= PH_ZERO;
			end else if (tick) begin
				rx_cnt_reg <= rx_cnt_reg + PH_STEP;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive shifting
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_shift_reg <= DATA_RST;
			rx_idx_reg   <= IDX_ZERO;
			rx_par_reg   <= 1'b0;
		end else if (rx_sample) begin
			case (rx_state_reg)
				RX_START: begin
					rx_shift_reg <= DATA_RST;
					rx_idx_reg   <= IDX_ZERO;
				end
				RX_DATA: begin
					rx_shift_reg[rx_idx_reg] <= rx_line_reg;
					rx_idx_reg               <= rx_idx_reg + IDX_STEP;
				end
				RX_PAR:  rx_par_reg <= rx_line_reg;
				default: rx_par_reg <= rx_par_reg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receive hold register and flags
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_hold_reg <= DATA_RST;
		end else if (rx_done && !rx_full_flag_reg) begin
			rx_hold_reg <= rx_data;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_full_flag_reg <= 1'b0;
			per_reg  <= 1'b0;
			fer_reg  <= 1'b0;
			overrun_flag_reg <= 1'b0;
		end else begin
			rx_full_flag_reg <= (rx_done & ~rx_full_flag_reg & ~stop_bad & ~par_bad) |
			            (rx_full_flag_reg & ~rx_full_clr_i);
			overrun_flag_reg <= (rx_done & rx_full_flag_reg) | (overrun_flag_reg & ~overrun_clr_i);
			fer_reg  <= (rx_done & stop_bad) | (fer_reg & ~framing_fault_clr_i);
			per_reg  <= (rx_done & par_bad) | (per_reg & ~parity_fault_clr_i);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign tx_buffer_empty_flag_o = tx_buffer_empty_flag_reg;
	assign tx_done_flag_o         = tx_done_flag_reg;
	assign rx_full_flag_o         = rx_full_flag_reg;
	assign parity_fault_flag_o    = per_reg;
	assign framing_fault_flag_o   = fer_reg;
	assign overrun_flag_o         = overrun_flag_reg;
	assign rx_hold_o              = rx_hold_reg;
	assign tx_empty_irq_o         = tx_irq_en_i & tx_buffer_empty_flag_reg;
	assign tx_done_irq_o          = done_irq_en_i & tx_done_flag_reg;
	assign rx_full_irq_o          = rx_irq_en_i & rx_full_flag_reg;
	assign rx_error_irq_o         = rx_irq_en_i & rx_err_any;
	assign tx_line_o              = tx_line_reg;
	assign tx_line_oe_o           = tx_on_i | break_pin_drive_i;
	assign ser_clk_pin_o          = ser_clk_reg;
	assign ser_clk_pin_oe_o       = ~clk_src_sel_hi_i & clk_src_sel_lo_i;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	AST_TX_OFF: assert property (!tx_on_i |=> tx_buffer_empty_flag_reg && tx_state_reg == TX_IDLE)
		else $error("transmit off did not force empty flag");
	AST_RX_OFF: assert property (!rx_on_i |=> $stable(rx_hold_reg))
		else $error("receive off changed hold register");
	AST_LOAD: assert property (tx_load |=> tx_buffer_empty_flag_reg && tx_shift_reg == $past(tx_hold_reg))
		else $error("load did not refill shifter and set empty flag");
	AST_START: assert property (tx_on_i && tx_state_reg == TX_START |=> tx_line_o == SPACE)
		else $error("start bit not space");
	AST_STOP: assert property (tx_on_i && tx_state_reg == TX_STOP |=> tx_line_o == MARK)
		else $error("stop bit not mark");
	AST_DONE: assert property (tx_finish |=> tx_done_flag_reg)
		else $error("done flag not set at idle stop bit");
	AST_CHAIN: assert property (stop_entry && tx_load |=> tx_buffer_empty_flag_reg ##[1:300] tx_state_reg == TX_START)
		else $error("back to back character not chained");
	AST_MID_CLK: assert property (bit_mid |=> ##1 ser_clk_pin_o)
		else $error("clock output not high from mid bit");
	AST_SYNC: assert property (rx_state_reg == RX_IDLE ##1 rx_state_reg == RX_START |-> rx_cnt_reg == PH_ZERO)
		else $error("receiver not synchronised on start edge");
	AST_FULL: assert property (rx_done && !rx_full_flag_reg && !stop_bad && !par_bad |=> rx_full_flag_reg && rx_hold_reg == $past(rx_data))
		else $error("clean character not delivered");
	AST_OVERRUN: assert property (rx_done && rx_full_flag_reg |=> overrun_flag_reg && $stable(rx_hold_reg))
		else $error("overrun not flagged or data overwritten");
	AST_FRAMING: assert property (rx_done && stop_bad && !rx_full_flag_reg |=> fer_reg && !rx_full_flag_reg)
		else $error("framing fault mishandled");
	AST_ERR_HALT: assert property (rx_err_any && rx_state_reg == RX_IDLE |=> rx_state_reg == RX_IDLE)
		else $error("reception resumed with fault flag set");

	COV_TX_END:  cover property (tx_finish);
	COV_CHAIN:   cover property (stop_entry && tx_load);
	COV_RX_OK:   cover property (rx_done && !rx_full_flag_reg && !stop_bad && !par_bad);
	COV_OVERRUN: cover property (rx_done && rx_full_flag_reg);

endmodule

// ===== bench/ast_far_end.sv
// Far-end serial transceiver model on the line.
// Assumes the bench sets bit_cyc and rx_len before traffic.
`timescale 1ns/1ps
module ast_far_end (
	// Clock
	input  wire logic clk_i,
	// Line from the block
	input  wire logic line_i,
	// Line to the block
	output logic      line_o
);
	int          bit_cyc = 32;
	int          rx_len  = 9;
	logic [11:0] got_q[$];
	logic [11:0] w;

	// ------------------------------------------------------------
	// Sender
	// ------------------------------------------------------------
	initial line_o = 1'b1;
	task automatic send(input logic [11:0] bits, input int n);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (bit_cyc) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_o <= bits[i];
			repeat (bit_cyc) @(posedge clk_i);
		end
		line_o <= 1'b1;
	endtask

	// ------------------------------------------------------------
	// Receiver, samples mid bit
	// ------------------------------------------------------------
	always begin
		@(negedge line_i);
		repeat (bit_cyc / 2) @(posedge clk_i);
		w = '0;
		for (int i = 0; i < rx_len; i++) begin
			repeat (bit_cyc) @(posedge clk_i);
			w[i] = line_i;
		end
		got_q.push_back(w);
	end
endmodule

// ===== bench/ast_txrx_test.sv
// Self-checking bench for the serial transmitter/receiver.
// Assumes ast_far_end on the line and a 100 MHz core clock.
`timescale 1ns/1ps
module ast_txrx_test;
	import ast_pkg::*;
	localparam int BIT = 32;
	logic       core_clk_i, arst_n_i, chr_7bit_i, parity_en_i, odd_parity_sel_i;
	logic       mp_mode_i, two_stop_i, clk_src_sel_hi_i, clk_src_sel_lo_i, tx_on_i, rx_on_i;
	logic       tx_irq_en_i, rx_irq_en_i, done_irq_en_i, break_pin_level_i, break_pin_drive_i;
	logic       tx_hold_we_i, addr_flag_bit_i, tx_empty_clr_i, rx_full_clr_i;
	logic       parity_fault_clr_i, framing_fault_clr_i, overrun_clr_i;
	logic       tx_buffer_empty_flag_o, tx_done_flag_o, rx_full_flag_o, parity_fault_flag_o;
	logic       framing_fault_flag_o, overrun_flag_o, tx_empty_irq_o, tx_done_irq_o;
	logic       rx_full_irq_o, rx_error_irq_o, rx_line_i, tx_line_o, tx_line_oe_o;
	logic       ser_clk_pin_i, ser_clk_pin_o, ser_clk_pin_oe_o, line_w, ab, prev;
	logic [7:0] bit_rate_i, tx_hold_data_i, rx_hold_o, d, d2;
	logic [5:0] flg;
	int         failures, total_checks, cyc, f, rises;
	int         fmts[7] = '{0, 2, 6, 17, 3, 10, 25};

	assign line_w = tx_line_oe_o ? tx_line_o : 1'b1;
	assign flg = {overrun_flag_o, framing_fault_flag_o, parity_fault_flag_o,
		rx_full_flag_o, tx_done_flag_o, tx_buffer_empty_flag_o};
	ast_txrx i_dut (.*);
	ast_far_end i_far (.clk_i(core_clk_i), .line_i(line_w), .line_o(rx_line_i));

	// ------------------------------------------------------------
	// Clocks and timeout
	// ------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc[0]) ser_clk_pin_i <= ~ser_clk_pin_i;
		if (cyc == 80000) begin
			failures++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Model and checks
	// ------------------------------------------------------------
	function automatic int flen(input int f);
		return (f[0] ? 7 : 8) + (f[1] | f[3]) + (f[4] ? 2 : 1);
	endfunction
	function automatic logic [11:0] frame(input logic [7:0] d, input int f, input logic ab);
		logic [11:0] w;
		int          n;
		logic        p;
		n = f[0] ? 7 : 8;
		w = '0;
		p = f[2];
		for (int i = 0; i < n; i++) begin
			w[i] = d[i];
			p ^= d[i];
		end
		if (f[3] || f[1]) w[n] = f[3] ? ab : p;
		for (int i = n + (f[1] | f[3]); i < flen(f); i++) w[i] = 1'b1;
		return w;
	endfunction
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic chk_frame(input logic [11:0] exp);
		int k;
		k = 0;
		while (i_far.got_q.size() == 0 && k < 4 * i_far.bit_cyc) begin
			@(negedge core_clk_i);
			k++;
		end
		chk("tx_frame", exp, i_far.got_q.size() ? i_far.got_q.pop_front() : 12'hXXX);
	endtask

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic wait_for(input int idx, input logic v, input int n);
		int k;
		k = 0;
		@(negedge core_clk_i);
		while (flg[idx] !== v && k < n) begin
			@(negedge core_clk_i);
			k++;
		end
	endtask
	task automatic set_fmt(input int f);
		@(posedge core_clk_i);
		{tx_on_i, rx_on_i} <= 2'h0;
		@(posedge core_clk_i);
		{two_stop_i, mp_mode_i, odd_parity_sel_i, parity_en_i, chr_7bit_i} <= f[4:0];
		i_far.rx_len = flen(f);
		repeat (i_far.bit_cyc) @(posedge core_clk_i);
		{tx_on_i, rx_on_i} <= 2'h3;
	endtask
	task automatic send_tx(input logic [7:0] d, input logic ab);
		@(posedge core_clk_i);
		tx_hold_data_i <= d;
		tx_hold_we_i <= 1'b1;
		addr_flag_bit_i <= ab;
		@(posedge core_clk_i);
		tx_hold_we_i <= 1'b0;
		tx_empty_clr_i <= 1'b1;
		@(posedge core_clk_i);
		tx_empty_clr_i <= 1'b0;
	endtask
	task automatic rx_frame(input logic [11:0] w, input int f);
		i_far.send(w, flen(f));
		repeat (2) @(negedge core_clk_i);
	endtask
	task automatic clr_rx();
		@(posedge core_clk_i);
		{rx_full_clr_i, parity_fault_clr_i, framing_fault_clr_i, overrun_clr_i} <= 4'hF;
		@(posedge core_clk_i);
		{rx_full_clr_i, parity_fault_clr_i, framing_fault_clr_i, overrun_clr_i} <= 4'h0;
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{chr_7bit_i, parity_en_i, odd_parity_sel_i, mp_mode_i, two_stop_i} = 5'h00;
		{clk_src_sel_hi_i, clk_src_sel_lo_i, tx_on_i, rx_on_i} = 4'h0;
		{tx_irq_en_i, rx_irq_en_i, done_irq_en_i, break_pin_level_i, break_pin_drive_i} = 5'h1E;
		{tx_hold_we_i, addr_flag_bit_i, tx_empty_clr_i, rx_full_clr_i} = 4'h0;
		{parity_fault_clr_i, framing_fault_clr_i, overrun_clr_i} = 3'h0;
		{tx_hold_data_i, bit_rate_i, ser_clk_pin_i, arst_n_i} = 18'h00004;
		{cyc, failures, total_checks} = '0;
		void'($urandom(32'h6410));
		repeat (12) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		foreach (fmts[j]) begin
			f = fmts[j];
			set_fmt(f);
			d = $urandom;
			d2 = $urandom;
			ab = $urandom;
			send_tx(d, ab);
			wait_for(0, 1'b1, 40);
			chk("tx_empty_irq", 1, tx_empty_irq_o);
			send_tx(d2, ~ab);
			wait_for(1, 1'b1, 30 * BIT);
			chk("tx_done_irq", 1, tx_done_irq_o);
			chk_frame(frame(d, f, ab));
			chk_frame(frame(d2, f, ~ab));
			rx_frame(frame(d, f, ab), f);
			chk("rx_full", 1, rx_full_flag_o);
			chk("rx_full_irq", 1, rx_full_irq_o);
			chk("rx_hold", f[0] ? {1'b0, d[6:0]} : d, rx_hold_o);
			clr_rx();
		end
		$display("test formats done");
		set_fmt(2);
		rx_frame(frame(d, 2, 0) ^ 12'h100, 2);
		chk("parity_flag", 1, parity_fault_flag_o);
		chk("rx_full", 0, rx_full_flag_o);
		chk("rx_hold", d, rx_hold_o);
		chk("rx_error_irq", 1, rx_error_irq_o);
		@(posedge core_clk_i);
		rx_on_i <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		chk("parity_flag", 1, parity_fault_flag_o);
		chk("rx_hold", d, rx_hold_o);
		@(posedge core_clk_i);
		rx_on_i <= 1'b1;
		rx_frame(frame(d2, 2, 0), 2);
		chk("rx_full", 0, rx_full_flag_o);
		chk("rx_hold", d, rx_hold_o);
		clr_rx();
		rx_frame(frame(d2, 2, 0) & 12'hDFF, 2);
		chk("framing_flag", 1, framing_fault_flag_o);
		chk("rx_hold", d2, rx_hold_o);
		repeat (12 * BIT) @(posedge core_clk_i);
		clr_rx();
		rx_frame(frame(d, 2, 0), 2);
		rx_frame(frame(d2, 2, 0), 2);
		chk("overrun_flag", 1, overrun_flag_o);
		chk("rx_hold", d, rx_hold_o);
		clr_rx();
		$display("test rx_errors done");
		send_tx(d, 0);
		send_tx(d2, 0);
		@(posedge core_clk_i);
		{tx_on_i, break_pin_level_i, break_pin_drive_i} <= 3'h1;
		repeat (2) @(negedge core_clk_i);
		chk("tx_empty", 1, tx_buffer_empty_flag_o);
		chk("tx_line", 2, {tx_line_oe_o, tx_line_o});
		@(posedge core_clk_i);
		{tx_on_i, break_pin_level_i, break_pin_drive_i} <= 3'h6;
		repeat (14 * BIT) @(negedge core_clk_i);
		i_far.got_q.delete();
		chk("tx_mark", 3, {tx_line_oe_o, tx_line_o});
		$display("test tx_off done");
		@(posedge core_clk_i);
		clk_src_sel_lo_i <= 1'b1;
		rises = 0;
		@(negedge core_clk_i);
		prev = ser_clk_pin_o;
		repeat (8 * BIT) begin
			@(negedge core_clk_i);
			rises += (ser_clk_pin_o && !prev);
			prev = ser_clk_pin_o;
		end
		chk("clk_out_rises", 8, rises);
		chk("clk_out_oe", 1, ser_clk_pin_oe_o);
		@(posedge core_clk_i);
		{clk_src_sel_hi_i, bit_rate_i} <= 9'h1FF;
		i_far.bit_cyc = 64;
		set_fmt(0);
		send_tx(d2, 0);
		wait_for(1, 1'b1, 40 * BIT);
		chk_frame(frame(d2, 0, 0));
		chk("clk_out_oe", 0, ser_clk_pin_oe_o);
		rx_frame(frame(d, 0, 0), 0);
		chk("rx_hold", d, rx_hold_o);
		$display("test clocks done");
		stop_test();
	end
endmodule
